// File: verilog/rxeim_regs.sv
// register bank: window and packet energy readback and modem interrupt mask
// Functional notes
// - window_energy_level holds the average antenna energy over the selected averaging window.
// - the window energy is a signed two's complement value in units of 1 dBm.
// - packet_energy_level captures the energy of the last packet and holds it until the next packet or a bus write to it with lane 0.
// - with the receive-done enable bit (bit 3) at 0 the receive-done interrupt is never raised.
// - the receive-done interrupt marks each successfully received packet.
// - with the receive-begin enable bit (bit 2) at 0 the receive-begin interrupt is never raised.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module rxeim_regs
(
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    input  wire logic [rxeim_pkg::BUS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [rxeim_pkg::BUS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    input  wire logic                             window_energy_valid,
    input  wire logic [7:0]                       window_energy_dbm,
    input  wire logic                             rx_begin_event,
    input  wire logic                             rx_done_event,
    input  wire logic [7:0]                       rx_packet_energy_dbm,
    output logic                                  rx_begin_irq,
    output logic                                  rx_done_irq,
    output logic [7:0]                            window_energy_level,
    output logic [7:0]                            packet_energy_level,
    output logic [7:0]                            modem_irq_mask
);
    import rxeim_pkg::*;

    typedef enum logic [1:0] {
        RXEIM_SEL_WINDOW,
        RXEIM_SEL_PACKET,
        RXEIM_SEL_MASK,
        RXEIM_SEL_NONE
    } rxeim_sel_t;

    function automatic rxeim_sel_t rxeim_decode(input logic [BUS_ADDR_W-1:0] a);
        rxeim_sel_t s;
        s = RXEIM_SEL_NONE;
        if (a == ADDR_WINDOW_EN) begin
            s = RXEIM_SEL_WINDOW;
        end else if (a == ADDR_PACKET_EN) begin
            s = RXEIM_SEL_PACKET;
        end else if (a == ADDR_IRQ_MASK) begin
            s = RXEIM_SEL_MASK;
        end
        return s;
    endfunction

    // write channel: address and data latched independently, response after both
    logic                  aw_held;
    logic                  w_held;
    logic [BUS_ADDR_W-1:0] aw_addr;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  do_write;
    rxeim_sel_t            wsel;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wsel          = rxeim_decode(aw_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == RXEIM_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // reserved high bits keep their reset ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modem_irq_mask <= MASK_RESET;
        end else if (do_write && w_lane0 && wsel == RXEIM_SEL_MASK) begin
            modem_irq_mask <= (MASK_RESET & ~MASK_WRITABLE) | (w_byte & MASK_WRITABLE);
        end
    end

    // hardware update wins over a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            window_energy_level <= ENERGY_RESET;
        end else if (window_energy_valid) begin
            window_energy_level <= window_energy_dbm;
        end else if (do_write && w_lane0 && wsel == RXEIM_SEL_WINDOW) begin
            window_energy_level <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            packet_energy_level <= ENERGY_RESET;
        end else if (rx_done_event) begin
            packet_energy_level <= rx_packet_energy_dbm;
        end else if (do_write && w_lane0 && wsel == RXEIM_SEL_PACKET) begin
            packet_energy_level <= w_byte;
        end
    end

    // interrupts are registered copies of their events, one cycle later, gated by the mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_done_irq  <= 1'b0;
            rx_begin_irq <= 1'b0;
        end else begin
            rx_done_irq  <= rx_done_event && modem_irq_mask[BIT_RX_DONE_EN];
            rx_begin_irq <= rx_begin_event && modem_irq_mask[BIT_RX_BEGIN_EN];
        end
    end

    // read channel: one read at a time, answer one cycle after address
    rxeim_sel_t rsel;
    assign rsel          = rxeim_decode(s_axi_araddr);
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (rsel)
                RXEIM_SEL_WINDOW: s_axi_rdata <= {24'h000000, window_energy_level};
                RXEIM_SEL_PACKET: s_axi_rdata <= {24'h000000, packet_energy_level};
                RXEIM_SEL_MASK:   s_axi_rdata <= {24'h000000, modem_irq_mask};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // assertions
    property p_done_masked;
        @(posedge aclk) disable iff (!aresetn)
        !modem_irq_mask[BIT_RX_DONE_EN] |=> !rx_done_irq;
    endproperty
    a_done_masked: assert property (p_done_masked) else $error("rx done irq while masked");

    property p_done_fires;
        @(posedge aclk) disable iff (!aresetn)
        rx_done_event && modem_irq_mask[BIT_RX_DONE_EN] |=> rx_done_irq;
    endproperty
    a_done_fires: assert property (p_done_fires) else $error("rx done irq missing");

    property p_begin_masked;
        @(posedge aclk) disable iff (!aresetn)
        !modem_irq_mask[BIT_RX_BEGIN_EN] |=> !rx_begin_irq;
    endproperty
    a_begin_masked: assert property (p_begin_masked) else $error("rx begin irq while masked");

    property p_begin_fires;
        @(posedge aclk) disable iff (!aresetn)
        rx_begin_event && modem_irq_mask[BIT_RX_BEGIN_EN] |=> rx_begin_irq;
    endproperty
    a_begin_fires: assert property (p_begin_fires) else $error("rx begin irq missing");

    property p_pkt_capture;
        @(posedge aclk) disable iff (!aresetn)
        rx_done_event |=> packet_energy_level == $past(rx_packet_energy_dbm);
    endproperty
    a_pkt_capture: assert property (p_pkt_capture) else $error("packet energy not captured");

    property p_pkt_hold;
        @(posedge aclk) disable iff (!aresetn)
        !rx_done_event && !do_write |=> $stable(packet_energy_level);
    endproperty
    a_pkt_hold: assert property (p_pkt_hold) else $error("packet energy changed");

    property p_win_update;
        @(posedge aclk) disable iff (!aresetn)
        window_energy_valid |=> window_energy_level == $past(window_energy_dbm);
    endproperty
    a_win_update: assert property (p_win_update) else $error("window energy not loaded");

    property p_win_signed;
        @(posedge aclk) disable iff (!aresetn)
        window_energy_valid && window_energy_dbm[7] |=> window_energy_level[7];
    endproperty
    a_win_signed: assert property (p_win_signed) else $error("window energy sign lost");

    property p_reserved;
        @(posedge aclk) disable iff (!aresetn)
        modem_irq_mask[7:4] == MASK_RESET[7:4];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mask bits changed");

    property p_rd_answer;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

    // bus answers must stand until taken; the master may stall for any time
    property p_wr_answer;
        @(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered");

    property p_b_stands;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stands: assert property (p_b_stands) else $error("write response dropped early");

    property p_r_stands;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stands: assert property (p_r_stands) else $error("read data dropped early");

    property p_r_upper;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_upper: assert property (p_r_upper) else $error("read data upper bits set");

    // an interrupt pulse must trace back to its own enabled event
    property p_done_cause;
        @(posedge aclk) disable iff (!aresetn)
        rx_done_irq |-> $past(rx_done_event) && $past(modem_irq_mask[BIT_RX_DONE_EN]);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("rx done irq without event");

    property p_begin_cause;
        @(posedge aclk) disable iff (!aresetn)
        rx_begin_irq |-> $past(rx_begin_event) && $past(modem_irq_mask[BIT_RX_BEGIN_EN]);
    endproperty
    a_begin_cause: assert property (p_begin_cause) else $error("rx begin irq without event");

    // only byte lane 0 carries the mask; other lanes are ignored
    property p_mask_load;
        @(posedge aclk) disable iff (!aresetn)
        do_write && w_lane0 && wsel == RXEIM_SEL_MASK
        |=> (modem_irq_mask & MASK_WRITABLE) == ($past(w_byte) & MASK_WRITABLE);
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("mask write not applied");

    property p_mask_strobe;
        @(posedge aclk) disable iff (!aresetn)
        do_write && !w_lane0 |=> $stable(modem_irq_mask);
    endproperty
    a_mask_strobe: assert property (p_mask_strobe) else $error("mask changed without lane 0");

    property p_win_write;
        @(posedge aclk) disable iff (!aresetn)
        do_write && w_lane0 && wsel == RXEIM_SEL_WINDOW && !window_energy_valid
        |=> window_energy_level == $past(w_byte);
    endproperty
    a_win_write: assert property (p_win_write) else $error("window energy write lost");

    c_done: cover property (@(posedge aclk) disable iff (!aresetn) rx_done_irq);
    c_begin: cover property (@(posedge aclk) disable iff (!aresetn) rx_begin_irq);
    c_mask_wr: cover property (@(posedge aclk) disable iff (!aresetn)
        do_write && wsel == RXEIM_SEL_MASK);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// File: verilog/rxeim_pkg.sv
// package for the receive energy and interrupt mask register bank
package rxeim_pkg;
    localparam int           ADDR_W          = 16;
    localparam logic [15:0]  OFF_WINDOW_EN   = 16'h2274;
    localparam logic [15:0]  OFF_PACKET_EN   = 16'h2275;
    localparam logic [15:0]  OFF_IRQ_MASK    = 16'h2277;
    // printed offsets are not all word aligned: byte address is index times four
    localparam logic [17:0]  ADDR_WINDOW_EN  = {OFF_WINDOW_EN, 2'b00};
    localparam logic [17:0]  ADDR_PACKET_EN  = {OFF_PACKET_EN, 2'b00};
    localparam logic [17:0]  ADDR_IRQ_MASK   = {OFF_IRQ_MASK, 2'b00};
    localparam int           BUS_ADDR_W      = 18;
    localparam int           BIT_RX_DONE_EN  = 3;
    localparam int           BIT_RX_BEGIN_EN = 2;
    localparam logic [7:0]   MASK_RESET      = 8'hf0;
    localparam logic [7:0]   MASK_WRITABLE   = 8'h0f;
    localparam logic [7:0]   ENERGY_RESET    = 8'h00;
    localparam logic [1:0]   RESP_OKAY       = 2'b00;
    localparam logic [1:0]   RESP_SLVERR     = 2'b10;
endpackage

// File: sim/test_rx_energy_and_irq_mask.sv
// self-checking bench for the receive energy and interrupt mask registers
`timescale 1ns/10ps
`default_nettype none
module test_rx_energy_and_irq_mask;
    import rxeim_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        bvalid, arready, rvalid, win_valid, begin_ev, done_ev, begin_irq, done_irq;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, m;
    logic [1:0]  bresp, rresp;
    logic [7:0]  win_dbm, pkt_dbm, win_lvl, pkt_lvl, mask_lvl, e, w, p;
    logic [33:0] exp_r[$], exp_b[$], exp_i[$];
    int          n_errors = 0;
    int          n_compared = 0;
    int          i;

    always #2 aclk = ~aclk;

    rxeim_regs rxeim_regs_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .window_energy_valid(win_valid), .window_energy_dbm(win_dbm),
        .rx_begin_event(begin_ev), .rx_done_event(done_ev), .rx_packet_energy_dbm(pkt_dbm),
        .rx_begin_irq(begin_irq), .rx_done_irq(done_irq), .window_energy_level(win_lvl),
        .packet_energy_level(pkt_lvl), .modem_irq_mask(mask_lvl)
    );

    logic [33:0] nx;

    task automatic judge(input logic [33:0] g, input logic [33:0] x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic cmp_read(input logic [33:0] g, input logic [33:0] x);
        judge(g, x);
    endtask

    task automatic cmp_resp(input logic [33:0] g, input logic [33:0] x);
        judge(g, x);
    endtask

    task automatic cmp_irq(input logic [33:0] g, input logic [33:0] x);
        judge(g, x);
    endtask

    task automatic cmp_left(input logic [33:0] g, input logic [33:0] x);
        judge(g, x);
    endtask

    task wrap_up;
        $display("TB: compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // an empty queue yields unknown, so an unexpected result never matches
    always @(posedge aclk) begin
        if (aresetn && rvalid && rready) begin
            nx = (exp_r.size() > 0) ? exp_r.pop_front() : 'x;
            cmp_read({rresp, rdata}, nx);
        end
        if (aresetn && bvalid && bready) begin
            nx = (exp_b.size() > 0) ? exp_b.pop_front() : 'x;
            cmp_resp({bresp, 32'h0}, nx);
        end
        if (aresetn && (begin_irq || done_irq)) begin
            nx = (exp_i.size() > 0) ? exp_i.pop_front() : 'x;
            cmp_irq({32'h0, done_irq, begin_irq}, nx);
        end
    end

    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] r);
        int   k;
        logic pa, pw, pb;
        @(posedge aclk);
        exp_b.push_back({r, 32'h0});
        {pa, pw, pb} = 3'b111;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        for (k = 0; k < 40 && (pa || pw || pb); k++) begin
            @(posedge aclk);
            if (pa && awready) begin pa = 1'b0; awvalid <= 1'b0; end
            if (pw && wready) begin pw = 1'b0; wvalid <= 1'b0; end
            if (pb && bvalid) begin pb = 1'b0; bready <= 1'b0; end
        end
        if (pa || pw || pb) begin n_errors++; wrap_up(); end
    endtask

    task automatic rd(input logic [17:0] a, input logic [33:0] x);
        int   k;
        logic pa, pr;
        @(posedge aclk);
        exp_r.push_back(x);
        {pa, pr} = 2'b11;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (k = 0; k < 40 && (pa || pr); k++) begin
            @(posedge aclk);
            if (pa && arready) begin pa = 1'b0; arvalid <= 1'b0; end
            if (pr && rvalid) begin pr = 1'b0; rready <= 1'b0; end
        end
        if (pa || pr) begin n_errors++; wrap_up(); end
    endtask

    // inputs flip after the pulse so a capture on the wrong edge shows up
    task automatic fire(input logic b, input logic d);
        e = 8'($urandom);
        w = 8'($urandom);
        if ((b && m[2]) || (d && m[3])) exp_i.push_back({32'h0, d & m[3], b & m[2]});
        @(posedge aclk);
        {begin_ev, done_ev, win_valid} <= {b, d, 1'b1};
        pkt_dbm <= e;
        win_dbm <= w;
        @(posedge aclk);
        {begin_ev, done_ev, win_valid} <= 3'b000;
        pkt_dbm <= ~e;
        win_dbm <= ~w;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, win_valid, begin_ev, done_ev} = '0;
        {awaddr, araddr, wdata, win_dbm, pkt_dbm} = '0;
        wstrb = 4'hf;
        m = 4'h0;
        void'($urandom(60));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_WINDOW_EN, {RESP_OKAY, 24'h0, ENERGY_RESET});
        rd(ADDR_PACKET_EN, {RESP_OKAY, 24'h0, ENERGY_RESET});
        rd(ADDR_IRQ_MASK, {RESP_OKAY, 24'h0, MASK_RESET});
        rd(18'h3fffc, {RESP_SLVERR, 32'h0});
        wr(18'h3fffc, 32'hff, RESP_SLVERR);
        $display("test reset_and_map done");
        for (i = 0; i < 4; i++) begin
            m = {i[1:0], 2'b01};
            wr(ADDR_IRQ_MASK, {28'h0, m}, RESP_OKAY);
            rd(ADDR_IRQ_MASK, {RESP_OKAY, 24'h0, MASK_RESET | {4'h0, m}});
            fire(1'b1, 1'b1);
            p = e;
            rd(ADDR_PACKET_EN, {RESP_OKAY, 24'h0, p});
            rd(ADDR_WINDOW_EN, {RESP_OKAY, 24'h0, w});
            fire(1'b1, 1'b0);
            rd(ADDR_PACKET_EN, {RESP_OKAY, 24'h0, p});
            $display("test mask %0d done", i);
        end
        wstrb <= 4'he;
        wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
        wstrb <= 4'hf;
        rd(ADDR_IRQ_MASK, {RESP_OKAY, 24'h0, MASK_RESET | {4'h0, m}});
        e = 8'($urandom);
        wr(ADDR_WINDOW_EN, {24'h0, e}, RESP_OKAY);
        rd(ADDR_WINDOW_EN, {RESP_OKAY, 24'h0, e});
        $display("test strobe_and_sw_write done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_IRQ_MASK, {RESP_OKAY, 24'h0, MASK_RESET});
        rd(ADDR_PACKET_EN, {RESP_OKAY, 24'h0, ENERGY_RESET});
        rd(ADDR_WINDOW_EN, {RESP_OKAY, 24'h0, ENERGY_RESET});
        $display("test mid_reset done");
        repeat (4) @(posedge aclk);
        cmp_left(34'(exp_r.size() + exp_b.size() + exp_i.size()), 34'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
